// file: floppy_host_register_port.sv
//Contract
// - Read-only diagnostic register at 3F7 or 377
// - Diagnostic bit 7 shows selected drive change
// - Main status read at 3F4/374, writes ignored
// - Status bit 7 set when data port ready
// - Status bit 6 gives transfer direction
// - Status bit 5 set in non-DMA mode
// - Status bit 4 set during read/write command
// - Bits 1/0 show drive B/A seeking independently
// - Stacked data port at 3F5 or 375
// - Address bit 0 picks status or data
// - Fifteen commands, multi-byte, written in sequence
// - Cylinder parameter valid from 0 to 76
// - Data length used only when size code zero
// - Transfer stops after last sector parameter
// - Gap length parameter passed to engine
// - Head select drives side output; H equals HD
// - Head load time 2 to 254 ms, 2 ms steps
// - Group select high primary, low secondary set
// - Result bytes readable only in result phase
`timescale 1ns/1ps
`include "fdc_consts.svh"

module floppy_host_register_port #(
  parameter int HLT_STEP_CYCLES = `HLT_STEP_MS * `MCLK_KHZ,
  parameter int FIFO_DEPTH      = `FIFO_DEPTH
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [9:0]  i_addr,
  input  wire logic        i_ior_n,
  input  wire logic        i_iow_n,
  input  wire logic [7:0]  i_data,
  output logic      [7:0]  o_data,
  output logic             o_data_oe,
  input  wire logic        i_drive_group_select,
  input  wire logic        i_drive_select,
  input  wire logic        i_disk_change_a,
  input  wire logic        i_disk_change_b,
  input  wire logic        i_seek_a,
  input  wire logic        i_seek_b,
  output logic             o_cmd_valid,
  output logic      [7:0]  o_cmd_data,
  input  wire logic        i_cmd_ready,
  input  wire logic        i_exec_done,
  input  wire logic        i_res_valid,
  input  wire logic [7:0]  i_res_data,
  output logic             o_res_ready,
  input  wire logic        i_sector_done,
  input  wire logic [7:0]  i_sector_num,
  output logic             o_stop_transfer,
  output logic             o_busy,
  output logic             o_non_dma,
  output logic             o_side_select,
  output logic      [7:0]  o_gap_length,
  output logic      [7:0]  o_last_sector,
  output logic      [14:0] o_sector_bytes,
  output logic      [23:0] o_head_load_cycles,
  output logic      [7:0]  o_cylinder,
  output logic             o_cylinder_invalid
);

  fdc_pkg::port_state_t s;  // Registered state
  fdc_pkg::port_state_t n;  // Next state

  logic [9:0] msr_addr;     // Status address of active set
  logic [9:0] diag_addr;    // Diagnostic address of active set
  logic       pair_hit;     // Status/data pair decoded
  logic       msr_sel;      // Status register selected
  logic       data_sel;     // Data port selected
  logic       diag_sel;     // Diagnostic register selected
  logic       rd_start;     // First cycle of a read strobe
  logic       wr_start;     // First cycle of a write strobe
  logic       fifo_ready;   // Command FIFO can take a byte
  logic       rqm;          // Data port ready for the host
  logic [7:0] status_byte;  // Assembled main status
  logic [7:0] diag_byte;    // Assembled diagnostic byte
  logic [3:0] len_now;      // Length of command in progress
  logic [4:0] op_now;       // Opcode of command in progress

  // Byte count of each command; unknown opcodes take one byte
  function automatic logic [3:0] cmd_len_f(input logic [4:0] op);
    case (op)
      `OP_READ_DATA, `OP_READ_DELETED, `OP_WRITE_DATA,
      `OP_WRITE_DELETED, `OP_READ_TRACK, `OP_SCAN_EQ,
      `OP_SCAN_LE, `OP_SCAN_HE: cmd_len_f = `LEN_RW;
      `OP_FORMAT:               cmd_len_f = `LEN_FORMAT;
      `OP_READ_ID, `OP_RECALIBRATE,
      `OP_SENSE_DRIVE:          cmd_len_f = `LEN_TWO;
      `OP_SPECIFY, `OP_SEEK:    cmd_len_f = `LEN_THREE;
      default:                  cmd_len_f = `LEN_ONE;
    endcase
  endfunction : cmd_len_f

  // Result byte count of each command
  function automatic logic [3:0] res_len_f(input logic [4:0] op);
    case (op)
      `OP_READ_DATA, `OP_READ_DELETED, `OP_WRITE_DATA,
      `OP_WRITE_DELETED, `OP_READ_TRACK, `OP_SCAN_EQ,
      `OP_SCAN_LE, `OP_SCAN_HE, `OP_READ_ID,
      `OP_FORMAT:               res_len_f = `RES_RW;
      `OP_SENSE_INT:            res_len_f = `RES_SENSE_INT;
      `OP_RECALIBRATE, `OP_SPECIFY,
      `OP_SEEK:                 res_len_f = `RES_NONE;
      default:                  res_len_f = `RES_ONE;
    endcase
  endfunction : res_len_f

  // Commands that move sector data
  function automatic logic is_rw_f(input logic [4:0] op);
    case (op)
      `OP_READ_DATA, `OP_READ_DELETED, `OP_WRITE_DATA,
      `OP_WRITE_DELETED, `OP_READ_TRACK, `OP_SCAN_EQ,
      `OP_SCAN_LE, `OP_SCAN_HE: is_rw_f = 1'b1;
      default:                  is_rw_f = 1'b0;
    endcase
  endfunction : is_rw_f

  // Address set follows the group select pin
  assign msr_addr  = i_drive_group_select ? `ADDR_MSR_PRI  : `ADDR_MSR_SEC;
  assign diag_addr = i_drive_group_select ? `ADDR_DIAG_PRI : `ADDR_DIAG_SEC;

  // Status and data share all bits but bit 0
  assign pair_hit = (i_addr[9:1] == msr_addr[9:1]);
  assign msr_sel  = pair_hit && !i_addr[0];
  assign data_sel = pair_hit && i_addr[0];
  assign diag_sel = (i_addr == diag_addr);

  // Strobes act once, on their leading edge
  assign rd_start = !i_ior_n && s.ior_n_d;
  assign wr_start = !i_iow_n && s.iow_n_d;

  // Ready only when the byte can really move
  always_comb begin
    case (s.phase)
      fdc_pkg::PH_IDLE,
      fdc_pkg::PH_CMD:    rqm = fifo_ready && !s.push_valid;
      fdc_pkg::PH_RESULT: rqm = s.res_valid;
      default:            rqm = 1'b0;
    endcase
  end

  // Main status, reserved bits held low
  always_comb begin
    status_byte                  = 8'h00;
    status_byte[`MSR_RQM_BIT]    = rqm;
    status_byte[`MSR_DIR_BIT]    = (s.phase == fdc_pkg::PH_RESULT);
    status_byte[`MSR_NDM_BIT]    = s.non_dma;
    status_byte[`MSR_BUSY_BIT]   = s.busy;
    status_byte[`MSR_SEEK_B_BIT] = i_seek_b;
    status_byte[`MSR_SEEK_A_BIT] = i_seek_a;
  end

  // Change flag of whichever drive is selected
  always_comb begin
    diag_byte                   = 8'h00;
    diag_byte[`DIAG_CHANGE_BIT] = i_drive_select ? i_disk_change_b
                                                 : i_disk_change_a;
  end

  // First byte fixes the command length
  assign op_now  = (s.byte_idx == 4'h0) ? i_data[4:0] : s.opcode;
  assign len_now = (s.byte_idx == 4'h0) ? cmd_len_f(i_data[4:0]) : s.cmd_len;

  // Next-state logic of the whole port
  always_comb begin
    n = s;
    n.ior_n_d = i_ior_n;
    n.iow_n_d = i_iow_n;

    // Bus drive lasts exactly as long as a decoded read
    n.oe = !i_ior_n && (msr_sel || data_sel || diag_sel);

    // Pending command byte leaves once the FIFO takes it
    if (s.push_valid && fifo_ready) begin
      n.push_valid = 1'b0;
    end

    // Read access: data captured on the strobe's leading edge
    if (rd_start) begin
      if (msr_sel) begin
        n.rdata = status_byte;
      end else if (diag_sel) begin
        n.rdata = diag_byte;
      end else if (data_sel) begin
        // Result bytes only exist in the result phase
        if (s.phase == fdc_pkg::PH_RESULT && s.res_valid) begin
          n.rdata     = s.res_buf;
          n.res_valid = 1'b0;
          n.res_left  = s.res_left - 4'h1;
          if (s.res_left == 4'h1) begin
            n.phase = fdc_pkg::PH_IDLE;
            n.busy  = 1'b0;
          end
        end else begin
          n.rdata = 8'h00;
        end
      end
    end

    // Write to data port; status address ignores writes
    if (wr_start && data_sel && rqm &&
        (s.phase == fdc_pkg::PH_IDLE || s.phase == fdc_pkg::PH_CMD)) begin
      n.push_valid = 1'b1;
      n.push_data  = i_data;
      n.byte_idx   = s.byte_idx + 4'h1;
      n.phase      = fdc_pkg::PH_CMD;
      if (s.byte_idx == 4'h0) begin
        n.opcode  = i_data[4:0];
        n.cmd_len = len_now;
      end
      // Parameter capture by byte position
      case (s.byte_idx)
        4'h1: begin
          if (op_now != `OP_SPECIFY) begin
            n.head_sel = i_data[2];
          end
        end
        4'h2: begin
          if (op_now == `OP_SPECIFY) begin
            n.head_load_time_param     = i_data[7:1];
            n.non_dma = i_data[0];
          end else if (op_now == `OP_FORMAT) begin
            n.size_code = i_data[2:0];
          end else begin
            n.cyl = i_data;
          end
        end
        4'h4: begin
          if (op_now == `OP_FORMAT) begin
            n.gap_length_param = i_data;
          end
        end
        4'h5: begin
          if (is_rw_f(op_now)) begin
            n.size_code = i_data[2:0];
          end
        end
        4'h6: begin
          if (is_rw_f(op_now)) begin
            n.last_sector_param = i_data;
          end
        end
        4'h7: begin
          if (is_rw_f(op_now)) begin
            n.gap_length_param = i_data;
          end
        end
        4'h8: begin
          if (is_rw_f(op_now)) begin
            n.data_length_param = i_data;
          end
        end
        default: begin
        end
      endcase
      // Last byte hands the command to the engine
      if (s.byte_idx + 4'h1 == len_now) begin
        n.phase    = fdc_pkg::PH_EXEC;
        n.byte_idx = 4'h0;
        n.busy     = is_rw_f(op_now);
        n.stop     = 1'b0;
      end
    end

    // Execution ends on the engine's pulse
    if (s.phase == fdc_pkg::PH_EXEC) begin
      // Sector matching the last sector parameter ends data
      if (i_sector_done && is_rw_f(s.opcode) && i_sector_num == s.last_sector_param) begin
        n.stop = 1'b1;
      end
      if (i_exec_done) begin
        n.res_left = res_len_f(s.opcode);
        if (res_len_f(s.opcode) == `RES_NONE) begin
          n.phase = fdc_pkg::PH_IDLE;
          n.busy  = 1'b0;
        end else begin
          n.phase = fdc_pkg::PH_RESULT;
        end
      end
    end

    // Result bytes fetched one at a time
    if (s.res_ready && i_res_valid) begin
      n.res_buf   = i_res_data;
      n.res_valid = 1'b1;
    end
    n.res_ready = (n.phase == fdc_pkg::PH_RESULT) && !n.res_valid;

    // Derived parameter views, registered for clean outputs
    n.cyl_err = (n.cyl > `CYL_MAX);
    if (n.size_code == 3'h0) begin
      n.sector_bytes = {7'h00, n.data_length_param};
    end else begin
      n.sector_bytes = 15'(`SECTOR_BASE << n.size_code);
    end
    // Product width kept, then trimmed to the output
    n.hlt_cycles = 24'(32'(n.head_load_time_param) * 32'(HLT_STEP_CYCLES));
  end

  // State register; HEAD_LOAD_TIME_PARAM keeps a defined value after reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s            <= '0;
      s.phase      <= fdc_pkg::PH_IDLE;
      s.ior_n_d    <= 1'b1;
      s.iow_n_d    <= 1'b1;
      s.head_load_time_param        <= `HLT_RESET;
    end else if (i_ce) begin
      s <= n;
    end
  end

  // Command bytes wait here until the engine drains them
  fdc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_in_valid  (s.push_valid),
    .i_in_data   (s.push_data),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_cmd_valid),
    .o_out_data  (o_cmd_data),
    .i_out_ready (i_cmd_ready)
  );

  // All outputs taken from state flip-flops
  assign o_data             = s.rdata;
  assign o_data_oe          = s.oe;
  assign o_res_ready        = s.res_ready;
  assign o_stop_transfer    = s.stop;
  assign o_busy             = s.busy;
  assign o_non_dma          = s.non_dma;
  assign o_side_select      = s.head_sel;
  assign o_gap_length       = s.gap_length_param;
  assign o_last_sector      = s.last_sector_param;
  assign o_sector_bytes     = s.sector_bytes;
  assign o_head_load_cycles = s.hlt_cycles;
  assign o_cylinder         = s.cyl;
  assign o_cylinder_invalid = s.cyl_err;

endmodule : floppy_host_register_port

// file: fdc_consts.svh
`ifndef FDC_CONSTS_SVH
`define FDC_CONSTS_SVH

// Register addresses, primary and secondary sets
`define ADDR_MSR_PRI      10'h3F4
`define ADDR_MSR_SEC      10'h374
`define ADDR_DATA_PRI     10'h3F5
`define ADDR_DATA_SEC     10'h375
`define ADDR_DIAG_PRI     10'h3F7
`define ADDR_DIAG_SEC     10'h377

// Main status and diagnostic bit positions
`define MSR_RQM_BIT       7
`define MSR_DIR_BIT       6
`define MSR_NDM_BIT       5
`define MSR_BUSY_BIT      4
`define MSR_SEEK_B_BIT    1
`define MSR_SEEK_A_BIT    0
`define DIAG_CHANGE_BIT   7

// Command opcodes, low five bits of the first byte
`define OP_READ_DATA      5'h06
`define OP_READ_DELETED   5'h0C
`define OP_WRITE_DATA     5'h05
`define OP_WRITE_DELETED  5'h09
`define OP_READ_TRACK     5'h02
`define OP_READ_ID        5'h0A
`define OP_FORMAT         5'h0D
`define OP_SCAN_EQ        5'h11
`define OP_SCAN_LE        5'h19
`define OP_SCAN_HE        5'h1D
`define OP_RECALIBRATE    5'h07
`define OP_SENSE_INT      5'h08
`define OP_SPECIFY        5'h03
`define OP_SENSE_DRIVE    5'h04
`define OP_SEEK           5'h0F

// Command and result byte counts
`define LEN_RW            4'h9
`define LEN_FORMAT        4'h6
`define LEN_TWO           4'h2
`define LEN_THREE         4'h3
`define LEN_ONE           4'h1
`define RES_RW            4'h7
`define RES_SENSE_INT     4'h2
`define RES_ONE           4'h1
`define RES_NONE          4'h0

// Parameter limits and timing
`define CYL_MAX           8'h4C
`define SECTOR_BASE       15'h0080
`define HLT_STEP_MS       2
`define MCLK_KHZ          20000
`define HLT_RESET         7'h01
`define FIFO_DEPTH        16

`endif

// file: fdc_pkg.sv
package fdc_pkg;

  // Host port phase, Gray coded along the usual path
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_CMD    = 2'b01,
    PH_EXEC   = 2'b11,
    PH_RESULT = 2'b10
  } phase_t;

  // Complete state of the host port
  typedef struct packed {
    phase_t      phase;
    logic        ior_n_d;
    logic        iow_n_d;
    logic [7:0]  rdata;
    logic        oe;
    logic [4:0]  opcode;
    logic [3:0]  byte_idx;
    logic [3:0]  cmd_len;
    logic [3:0]  res_left;
    logic [7:0]  res_buf;
    logic        res_valid;
    logic        res_ready;
    logic        push_valid;
    logic [7:0]  push_data;
    logic        busy;
    logic        non_dma;
    logic [6:0]  head_load_time_param;
    logic [23:0] hlt_cycles;
    logic [7:0]  data_length_param;
    logic [7:0]  last_sector_param;
    logic [7:0]  gap_length_param;
    logic [2:0]  size_code;
    logic [14:0] sector_bytes;
    logic        head_sel;
    logic [7:0]  cyl;
    logic        cyl_err;
    logic        stop;
  } port_state_t;

endpackage : fdc_pkg

// file: fdc_fifo.sv
`timescale 1ns/1ps

module fdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        in_ready;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_state_t;

  fifo_state_t s;  // Registered state
  fifo_state_t n;  // Next state

  // Output stage refills whenever empty or consumed
  always_comb begin
    n = s;
    if (!s.out_valid || i_out_ready) begin
      if (s.count != '0) begin
        n.out_data  = s.mem[s.rptr];
        n.out_valid = 1'b1;
        n.rptr      = s.rptr + 1'b1;
        n.count     = n.count - 1'b1;
      end else begin
        n.out_valid = 1'b0;
      end
    end
    // Push only while ready was shown
    if (i_in_valid && s.in_ready) begin
      n.mem[s.wptr] = i_in_data;
      n.wptr        = s.wptr + 1'b1;
      n.count       = n.count + 1'b1;
    end
    // Output register counts as a slot, so sixteen words in all
    n.in_ready = ((n.count + (AW+1)'(n.out_valid)) != (AW+1)'(DEPTH));
  end

  // State register with synchronous reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s          <= '0;
      s.in_ready <= 1'b1;
    end else if (i_ce) begin
      s <= n;
    end
  end

  assign o_in_ready  = s.in_ready;
  assign o_out_valid = s.out_valid;
  assign o_out_data  = s.out_data;

endmodule : fdc_fifo

// file: fdc_port_asserts.sv
`timescale 1ns/1ps
`include "fdc_consts.svh"

// Port-level checks, watching the top module's pins only
module fdc_port_asserts #(
  parameter int HLT_STEP_CYCLES = 4
) (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic [9:0]  i_addr,
  input wire logic        i_ior_n,
  input wire logic        i_iow_n,
  input wire logic        i_drive_group_select,
  input wire logic        i_drive_select,
  input wire logic        i_disk_change_a,
  input wire logic        i_disk_change_b,
  input wire logic        i_seek_a,
  input wire logic        i_seek_b,
  input wire logic        i_sector_done,
  input wire logic [7:0]  i_sector_num,
  input wire logic [7:0]  o_data,
  input wire logic        o_data_oe,
  input wire logic        o_busy,
  input wire logic        o_non_dma,
  input wire logic        o_side_select,
  input wire logic        o_stop_transfer,
  input wire logic [7:0]  o_last_sector,
  input wire logic [7:0]  o_cylinder,
  input wire logic        o_cylinder_invalid,
  input wire logic [23:0] o_head_load_cycles
);
  logic msr_hit;  // Status address of the active set
  logic diag_hit; // Diagnostic address of the active set
  assign msr_hit  = i_addr == (i_drive_group_select ? `ADDR_MSR_PRI : `ADDR_MSR_SEC);
  assign diag_hit = i_addr == (i_drive_group_select ? `ADDR_DIAG_PRI : `ADDR_DIAG_SEC);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // First low cycle of a read strobe at a decoded place
  sequence s_msr_rd; $fell(i_ior_n) && msr_hit; endsequence
  sequence s_diag_rd; $fell(i_ior_n) && diag_hit; endsequence
  // Strobe back high for two cycles
  sequence s_rd_idle; i_ior_n [*2]; endsequence

  property p_msr_oe; s_msr_rd |=> o_data_oe; endproperty
  property p_msr_mode; s_msr_rd |=> o_data[5] == $past(o_non_dma) && o_data[4] == $past(o_busy); endproperty
  property p_msr_rsvd; s_msr_rd |=> o_data[3:2] == 2'b00; endproperty
  property p_msr_seek; s_msr_rd |=> o_data[1] == $past(i_seek_b) && o_data[0] == $past(i_seek_a); endproperty
  property p_diag;
    s_diag_rd |=> o_data == {($past(i_drive_select) ? $past(i_disk_change_b) : $past(i_disk_change_a)), 7'h00};
  endproperty
  property p_oe_rel; s_rd_idle |-> !o_data_oe; endproperty
  property p_stop_set; i_sector_done && o_busy && i_sector_num == o_last_sector |=> o_stop_transfer; endproperty
  property p_stop_cause; $rose(o_stop_transfer) |-> $past(i_sector_done); endproperty
  property p_cyl; $stable(o_cylinder) |-> o_cylinder_invalid == (o_cylinder > 8'h4C); endproperty
  // Only whole steps, never beyond the top setting
  property p_hlt;
    o_head_load_cycles % HLT_STEP_CYCLES == 0 && o_head_load_cycles <= 127 * HLT_STEP_CYCLES;
  endproperty
  property p_side; $changed(o_side_select) |-> !$past(i_iow_n, 1) || !$past(i_iow_n, 2); endproperty
  property p_busy_end; $fell(o_busy) |-> !$past(i_ior_n, 1) || !$past(i_ior_n, 2); endproperty

  a_msr_oe: assert property (p_msr_oe) else $error("status read not answered");
  a_msr_mode: assert property (p_msr_mode) else $error("status mode bits wrong");
  a_msr_rsvd: assert property (p_msr_rsvd) else $error("reserved status bits set");
  a_msr_seek: assert property (p_msr_seek) else $error("seek bits wrong");
  a_diag: assert property (p_diag) else $error("diagnostic byte wrong");
  a_oe_rel: assert property (p_oe_rel) else $error("bus still driven");
  a_stop_set: assert property (p_stop_set) else $error("no stop at last sector");
  a_stop_cause: assert property (p_stop_cause) else $error("stop without sector");
  a_cyl: assert property (p_cyl) else $error("cylinder range flag wrong");
  a_hlt: assert property (p_hlt) else $error("head load count off step");
  a_side: assert property (p_side) else $error("side moved without write");
  a_busy_end: assert property (p_busy_end) else $error("busy ended without read");
endmodule : fdc_port_asserts

// file: host_model.sv
`timescale 1ns/1ps

// Processor side: strobed I/O cycles on the byte bus
module host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_group,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_oe,
  output logic      [9:0] o_addr,
  output logic            o_ior_n,
  output logic            o_iow_n,
  output logic      [7:0] o_data
);
  initial begin
    o_addr = 10'h000;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_data = 8'h00;
  end

  // Read: strobe low three edges, answer taken at the last
  task automatic io_rd(input logic [3:0] off, output logic [7:0] d, output logic oe);
    @(posedge i_mclk);
    o_addr <= {(i_group ? 6'h3F : 6'h37), off};
    o_ior_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    d = i_rd_data;
    oe = i_rd_oe;
    o_ior_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask : io_rd

  // Write: released data shows its inverse, not a stale copy
  task automatic io_wr(input logic [3:0] off, input logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= {(i_group ? 6'h3F : 6'h37), off};
    o_data <= d;
    o_iow_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    o_iow_n <= 1'b1;
    o_data <= ~d;
    repeat (2) @(posedge i_mclk);
  endtask : io_wr

  // Data writes wait for ready with host-to-device direction
  task automatic dat_wr(input logic [7:0] d);
    logic [7:0] s;
    logic oe;
    do io_rd(4'h4, s, oe); while (s[7] !== 1'b1 || s[6] !== 1'b0);
    io_wr(4'h5, d);
  endtask : dat_wr

  // Data reads wait for ready with device-to-host direction
  task automatic dat_rd(output logic [7:0] d);
    logic [7:0] s;
    logic oe;
    do io_rd(4'h4, s, oe); while (s[7] !== 1'b1 || s[6] !== 1'b1);
    io_rd(4'h5, d, oe);
  endtask : dat_rd
endmodule : host_model

// file: floppy_host_register_port_test.sv
`timescale 1ns/1ps

// Checker rides on the port, pins matched by name
bind floppy_host_register_port fdc_port_asserts #(.HLT_STEP_CYCLES(HLT_STEP_CYCLES)) i_chk (.*);

module floppy_host_register_port_test;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_drive_group_select = 1'b1;
  logic i_drive_select = 1'b0;
  logic i_disk_change_a = 1'b0;
  logic i_disk_change_b = 1'b0;
  logic i_seek_a = 1'b0;
  logic i_seek_b = 1'b0;
  logic i_cmd_ready = 1'b1;
  logic i_ce = 1'b1, i_res_valid = 1'b1;  // Engine always offers a result byte
  logic i_exec_done = 1'b0;
  logic i_sector_done = 1'b0;
  logic [7:0] i_sector_num = 8'h00;
  logic [7:0] res_cnt = 8'h00; // Result bytes handed over so far
  logic grp = 1'b1;            // Address set the host aims at
  logic [9:0] i_addr;
  logic i_ior_n, i_iow_n, o_data_oe, o_cmd_valid, o_res_ready, o_stop_transfer;
  logic o_busy, o_non_dma, o_side_select, o_cylinder_invalid;
  logic [7:0] i_data, o_data, o_cmd_data, o_gap_length, o_last_sector, o_cylinder, i_res_data;
  logic [14:0] o_sector_bytes;
  logic [23:0] o_head_load_cycles;
  int n_errors = 0;
  int comparisons = 0;

  initial forever #25 i_mclk = ~i_mclk;

  // Engine side: valid held high, next byte after each take
  assign i_res_data = 8'hA0 + res_cnt;
  always @(posedge i_mclk) if (o_res_ready === 1'b1) res_cnt <= res_cnt + 8'h01;

  host_model h (.i_mclk(i_mclk), .i_group(grp), .i_rd_data(o_data), .i_rd_oe(o_data_oe),
    .o_addr(i_addr), .o_ior_n(i_ior_n), .o_iow_n(i_iow_n), .o_data(i_data));

  // Short head-load step keeps counts small
  floppy_host_register_port #(.HLT_STEP_CYCLES(4), .FIFO_DEPTH(16)) i_dut (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Engine ends execution with a one-cycle pulse
  task automatic pulse_done;
    i_exec_done <= 1'b1;
    @(posedge i_mclk);
    i_exec_done <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask : pulse_done

  // Specify bytes: opcode, step rates, load time 5 with non-DMA set
  function automatic logic [7:0] spec(input int i);
    return (i % 3 == 0) ? 8'h03 : ((i % 3 == 1) ? 8'h00 : 8'h0B);
  endfunction : spec

  // Idle status, ignored write, diag and seek bits, address sets
  task automatic t_regs;
    logic [7:0] d;
    logic oe;
    h.io_rd(4'h4, d, oe);
    chk(d, 8'h80, "idle status");
    chk(oe, 1'b1, "status drive");
    h.io_wr(4'h4, 8'hFF);
    h.io_rd(4'h4, d, oe);
    chk(d, 8'h80, "status after write");
    for (int i = 0; i < 4; i++) begin
      i_drive_select <= i[0];
      i_disk_change_a <= i[1];
      i_disk_change_b <= !i[1];
      i_seek_a <= i[0];
      i_seek_b <= i[1];
      h.io_rd(4'h7, d, oe);
      chk(d, {(i[0] ? !i[1] : i[1]), 7'h00}, "diag byte");
      h.io_rd(4'h4, d, oe);
      chk(d[1:0], i[1:0], "seek bits");
    end
    i_drive_group_select <= 1'b0;
    grp <= 1'b0;
    h.io_rd(4'h4, d, oe);
    chk(d, 8'h83, "secondary status");
    grp <= 1'b1;
    h.io_rd(4'h4, d, oe);
    chk(oe, 1'b0, "primary ignored");
    i_drive_group_select <= 1'b1;
  endtask : t_regs

  // Engine stalls while specify commands fill the buffer, then drains
  task automatic t_fill;
    logic [7:0] d;
    logic oe;
    int k;
    i_cmd_ready <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      h.dat_wr(spec(i));
      if (i % 3 == 2) pulse_done();
    end
    h.io_rd(4'h4, d, oe);
    chk(d[7], 1'b0, "full buffer ready");
    chk(d[5], 1'b1, "non-DMA bit");
    chk(o_non_dma, 1'b1, "non-DMA out");
    chk(o_head_load_cycles, 24'd20, "head load");
    i_cmd_ready <= 1'b1;
    k = 0;
    for (int i = 0; i < 100 && k < 16; i++) begin
      @(posedge i_mclk);
      if (o_cmd_valid === 1'b1) begin
        chk(o_cmd_data, spec(k), "byte order");
        k++;
      end
    end
    chk(k, 16, "bytes drained");
    h.dat_wr(8'h00);
    h.dat_wr(8'h0B);
    pulse_done();
    h.io_rd(4'h4, d, oe);
    chk(d[7], 1'b1, "ready again");
  endtask : t_fill

  // Read-data command: parameters, last sector stop, result phase
  task automatic t_rw(input logic [7:0] cyl, input logic [7:0] n, input logic [14:0] nb);
    logic [7:0] d;
    logic [7:0] e;
    logic oe;
    logic [7:0] b [9];
    b = '{8'h06, 8'h04, cyl, 8'h01, 8'h01, n, 8'h03, 8'h1B, 8'h40};
    e = 8'hA0 + res_cnt;
    for (int i = 0; i < 9; i++) h.dat_wr(b[i]);
    h.io_rd(4'h4, d, oe);
    chk(d[4], 1'b1, "busy bit");
    chk(o_side_select, 1'b1, "side");
    chk(o_gap_length, 8'h1B, "gap");
    chk(o_sector_bytes, nb, "sector bytes");
    chk(o_cylinder_invalid, cyl > 8'h4C, "cylinder flag");
    h.io_rd(4'h5, d, oe);
    chk(d, 8'h00, "data read in exec");
    for (int s = 1; s < 4; s++) begin
      chk(o_stop_transfer, 1'b0, "early stop");
      i_sector_num <= s[7:0];
      i_sector_done <= 1'b1;
      @(posedge i_mclk);
      i_sector_done <= 1'b0;
      repeat (2) @(posedge i_mclk);
    end
    chk(o_stop_transfer, 1'b1, "stop at last");
    pulse_done();
    h.io_rd(4'h4, d, oe);
    chk(d[6], 1'b1, "direction out");
    for (int i = 0; i < 7; i++) begin
      h.dat_rd(d);
      chk(d, e + i[7:0], "result byte");
    end
    h.io_rd(4'h4, d, oe);
    chk(d[6], 1'b0, "direction in");
    chk(o_busy, 1'b0, "busy cleared");
  endtask : t_rw

  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_fill();
    t_rw(8'h4D, 8'h00, 15'h0040);
    t_rw(8'h4C, 8'h02, 15'h0200);
    finish_test();
  end

  // Run is well under a thousand cycles
  initial begin
    repeat (30000) @(posedge i_mclk);
    n_errors++;
    finish_test();
  end
endmodule : floppy_host_register_port_test
